/* File: design/pocx_map.svh */
// Purpose: register map, field positions and timing figures of the printer output channel
// Assumes: APB, 32-bit data, one aligned word per register
// Notes:   definitions only
`ifndef POCX_MAP_SVH
`define POCX_MAP_SVH

`define POCX_ADDR_W        8
`define POCX_OFF_CTRL      8'h00
`define POCX_OFF_DATA      8'h04
`define POCX_OFF_STATUS    8'h08
`define POCX_OFF_COUNT     8'h0C

`define POCX_CTRL_LOAD     0
`define POCX_CTRL_DONE     1

`define POCX_ST_XMIT       0
`define POCX_ST_EVENT      1
`define POCX_ST_REFUSED    2
`define POCX_ST_SESSION    3
`define POCX_ST_DEMAND     4
`define POCX_ST_AVAIL      5

`define POCX_CHAR_W        6
`define POCX_REGION_CHARS  1024
`define POCX_FIFO_DEPTH    8
`define POCX_STORE_DIV     4
`define POCX_EOM_CODE      6'h0F

`define POCX_CLK_NS        8
`define POCX_AVAIL_DROP_NS 4000
`define POCX_AVAIL_DROP_CYC (`POCX_AVAIL_DROP_NS / `POCX_CLK_NS)

`endif

/* File: design/pocx_pkg.sv */
// Purpose: types of the printer output channel
// Assumes: nothing beyond the map header
// Notes:   constants live in pocx_map.svh
package pocx_pkg;
   typedef enum logic [1:0] {
      TX_IDLE,
      TX_FETCH,
      TX_WAIT_DEMAND,
      TX_PRESENT
   } pocx_tx_state_t;
endpackage : pocx_pkg

/* File: design/pocx_channel.sv */
// Purpose: one printer output channel: APB load path, character store, printer handshake
// Assumes: char_demand synchronous to ref_clk; APB master holds requests until pready
// Notes:   the store is flip-flops; loads pass through a small FIFO paced by a divider
//
// Added by the designer: the APB interface to the registers and the register offsets.
`timescale 1ns/1ns
`include "pocx_map.svh"

////////////////////////////////////////////////////////////////////////////////
module pocx_fifo #(
   parameter int WIDTH = `POCX_CHAR_W,
   parameter int DEPTH = `POCX_FIFO_DEPTH
) (
   // clock and reset
   input  wire logic             ref_clk,
   input  wire logic             sys_rst,
   // fill side
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   // drain side
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int PW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [PW-1:0]    wr_q;
   logic [PW-1:0]    rd_q;
   logic [PW:0]      cnt_q;
   wire              push = in_valid && in_ready;
   wire              pop  = out_valid && out_ready;

   assign in_ready  = (cnt_q != (PW+1)'(DEPTH));
   assign out_valid = (cnt_q != '0);
   assign out_data  = mem_q[rd_q];

   function automatic logic [PW-1:0] wrap_inc(input logic [PW-1:0] p);
      wrap_inc = (p == PW'(DEPTH - 1)) ? '0 : p + 1'b1;
   endfunction : wrap_inc

   always_ff @(posedge ref_clk) begin
      if (push) begin
         mem_q[wr_q] <= in_data;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         wr_q  <= '0;
         rd_q  <= '0;
         cnt_q <= '0;
      end else begin
         if (push) begin
            wr_q <= wrap_inc(wr_q);
         end
         if (pop) begin
            rd_q <= wrap_inc(rd_q);
         end
         cnt_q <= cnt_q + (PW+1)'(push) - (PW+1)'(pop);
      end
   end
endmodule : pocx_fifo

////////////////////////////////////////////////////////////////////////////////
module pocx_channel
   import pocx_pkg::*;
#(
   parameter int                      REGION_CHARS     = `POCX_REGION_CHARS,
   parameter int                      FIFO_DEPTH       = `POCX_FIFO_DEPTH,
   parameter int                      STORE_DIV        = `POCX_STORE_DIV,
   parameter logic [`POCX_CHAR_W-1:0] END_MESSAGE_CODE = `POCX_EOM_CODE
) (
   // clock and reset
   input  wire logic                    ref_clk,
   input  wire logic                    sys_rst,
   // apb slave
   input  wire logic [`POCX_ADDR_W-1:0] paddr,
   input  wire logic                    psel,
   input  wire logic                    penable,
   input  wire logic                    pwrite,
   input  wire logic [31:0]             pwdata,
   output logic      [31:0]             prdata,
   output logic                         pready,
   output logic                         pslverr,
   // console printer lines
   input  wire logic                    char_demand,
   output logic      [6:0]              char_data,
   output logic                         char_avail,
   // processor events
   output logic                         display_int,
   output logic                         transmitting
);
   localparam int CW = `POCX_CHAR_W;
   localparam int AW = $clog2(REGION_CHARS) + 1;
   localparam int DW = $clog2(STORE_DIV + 1);

   ////////////////////////////////////////////////////////////////////////////
   // odd parity over the six data lines
   function automatic logic odd_par(input logic [CW-1:0] c);
      odd_par = ~(^c);
   endfunction : odd_par

   ////////////////////////////////////////////////////////////////////////////
   // state
   pocx_tx_state_t   tx_q;
   logic [CW-1:0]    store_q [REGION_CHARS];
   logic [AW-1:0]    wr_idx_q;
   logic [AW-1:0]    rd_idx_q;
   logic [AW-1:0]    sent_q;
   logic             session_q;
   logic             closing_q;
   logic             xmit_q;
   logic             last_q;
   logic             event_q;
   logic             refused_q;
   logic             disp_q;
   logic [6:0]       out_char_q;
   logic             avail_q;
   logic [DW-1:0]    div_q;
   logic [31:0]      prdata_q;
   logic             pready_q;
   logic             pslverr_q;

   ////////////////////////////////////////////////////////////////////////////
   // apb decode: one wait state, answer registered
   wire access    = psel && penable;
   wire take      = access && pready_q;
   wire hit_ctrl  = (paddr == `POCX_OFF_CTRL);
   wire hit_data  = (paddr == `POCX_OFF_DATA);
   wire hit_stat  = (paddr == `POCX_OFF_STATUS);
   wire hit_count = (paddr == `POCX_OFF_COUNT);
   wire mapped    = hit_ctrl || hit_data || hit_stat || hit_count;
   wire fifo_in_ready;
   wire fifo_out_valid;
   wire [CW-1:0] fifo_out_data;
   // a data write waits in the access phase while the fifo is full
   wire can_answer = !(pwrite && hit_data && session_q && !fifo_in_ready);

   wire wr_take   = take && pwrite;
   wire ld_req    = wr_take && hit_ctrl && pwdata[`POCX_CTRL_LOAD];
   wire done_req  = wr_take && hit_ctrl && pwdata[`POCX_CTRL_DONE];
   wire ev_clear  = wr_take && hit_stat && pwdata[`POCX_ST_EVENT];
   wire rf_clear  = wr_take && hit_stat && pwdata[`POCX_ST_REFUSED];
   wire data_push = wr_take && hit_data && session_q;

   // load checks look only at transmitting, the load session and demand, never at char_avail
   wire ld_busy   = ld_req && (xmit_q || session_q);
   wire ld_unavl  = ld_req && !ld_busy && !char_demand;
   wire ld_ok     = ld_req && !ld_busy && char_demand;

   wire [31:0] status_word = {26'h0000000,
                              avail_q,
                              char_demand,
                              session_q,
                              refused_q,
                              event_q,
                              xmit_q};

   wire [31:0] rd_mux = hit_stat  ? status_word :
                        hit_count ? 32'(sent_q) :
                        hit_ctrl  ? {30'h00000000, closing_q, session_q} :
                                    32'h00000000;

   ////////////////////////////////////////////////////////////////////////////
   // store fill, paced by a divider so the fifo really backs up
   wire div_tick  = (div_q == DW'(STORE_DIV - 1));
   wire room      = (wr_idx_q != AW'(REGION_CHARS));
   wire drain     = session_q && div_tick && fifo_out_valid;
   wire close_now = closing_q && !fifo_out_valid;
   wire loaded_any = (wr_idx_q != '0);

   pocx_fifo #(
      .WIDTH (CW),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .ref_clk   (ref_clk),
      .sys_rst   (sys_rst),
      .in_valid  (data_push),
      .in_ready  (fifo_in_ready),
      .in_data   (pwdata[CW-1:0]),
      .out_valid (fifo_out_valid),
      .out_ready (drain),
      .out_data  (fifo_out_data)
   );

   always_ff @(posedge ref_clk) begin
      if (drain && room) begin
         store_q[wr_idx_q[AW-2:0]] <= fifo_out_data;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // transmit sequencing
   wire [CW-1:0] cur_char  = store_q[rd_idx_q[AW-2:0]];
   wire          end_hit   = (cur_char == END_MESSAGE_CODE);
   wire          is_last   = ((rd_idx_q + 1'b1) == wr_idx_q) || end_hit;
   wire          tx_finish = (tx_q == TX_PRESENT) && !char_demand && last_q;
   wire          disp_set  = ld_busy || ld_unavl || tx_finish;

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         tx_q       <= TX_IDLE;
         rd_idx_q   <= '0;
         sent_q     <= '0;
         xmit_q     <= 1'b0;
         last_q     <= 1'b0;
         out_char_q <= 7'h00;
         avail_q    <= 1'b0;
      end else begin
         case (tx_q)
            TX_IDLE: begin
               if (close_now && loaded_any) begin
                  xmit_q   <= 1'b1;
                  rd_idx_q <= '0;
                  sent_q   <= '0;
                  tx_q     <= TX_FETCH;
               end
            end
            TX_FETCH: begin
               out_char_q <= {odd_par(cur_char), cur_char};
               last_q     <= is_last;
               rd_idx_q   <= rd_idx_q + 1'b1;
               tx_q       <= TX_WAIT_DEMAND;
            end
            TX_WAIT_DEMAND: begin
               // demand stuck low parks here, no timeout
               if (char_demand) begin
                  avail_q <= 1'b1;
                  tx_q    <= TX_PRESENT;
               end
            end
            TX_PRESENT: begin
               // demand stuck high parks here with one character sent
               if (!char_demand) begin
                  avail_q <= 1'b0;
                  sent_q  <= sent_q + 1'b1;
                  if (last_q) begin
                     xmit_q <= 1'b0;
                     tx_q   <= TX_IDLE;
                  end else begin
                     tx_q <= TX_FETCH;
                  end
               end
            end
            default: begin
               tx_q <= TX_IDLE;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // load session and events
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         session_q <= 1'b0;
         closing_q <= 1'b0;
         wr_idx_q  <= '0;
         div_q     <= '0;
      end else begin
         div_q <= div_tick ? '0 : div_q + 1'b1;
         if (ld_ok) begin
            session_q <= 1'b1;
            wr_idx_q  <= '0;
         end else if (drain && room) begin
            wr_idx_q <= wr_idx_q + 1'b1;
         end
         if (done_req && session_q) begin
            closing_q <= 1'b1;
         end else if (close_now) begin
            closing_q <= 1'b0;
            session_q <= 1'b0;
         end
      end
   end

   // sticky event and refused flags plus the one-cycle interrupt pulse: a hardware set in the clearing cycle wins
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         event_q   <= 1'b0;
         refused_q <= 1'b0;
         disp_q    <= 1'b0;
      end else begin
         disp_q    <= disp_set;
         event_q   <= disp_set || (event_q && !ev_clear);
         refused_q <= ld_busy || ld_unavl || (refused_q && !rf_clear);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // apb answer
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q  <= 32'h00000000;
      end else if (take) begin
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
      end else if (access && can_answer) begin
         pready_q  <= 1'b1;
         pslverr_q <= !mapped;
         prdata_q  <= pwrite ? 32'h00000000 : rd_mux;
      end
   end

   assign prdata       = prdata_q;
   assign pready       = pready_q;
   assign pslverr      = pslverr_q;
   assign char_data    = out_char_q;
   assign char_avail   = avail_q;
   assign display_int  = disp_q;
   assign transmitting = xmit_q;
endmodule : pocx_channel

/* File: verif/pocx_channel_props.sv */
// Purpose: concurrent checks on the printer output channel ports
// Assumes: one clock domain, synchronous active-high reset
// Notes:   bound to every instance of the channel
`timescale 1ns/1ns
`include "pocx_map.svh"
module pocx_channel_props (
   // clock and reset
   input wire logic                    ref_clk,
   input wire logic                    sys_rst,
   // apb
   input wire logic [`POCX_ADDR_W-1:0] paddr,
   input wire logic                    psel,
   input wire logic                    penable,
   input wire logic                    pwrite,
   input wire logic [31:0]             pwdata,
   input wire logic [31:0]             prdata,
   input wire logic                    pready,
   input wire logic                    pslverr,
   // printer lines and events
   input wire logic                    char_demand,
   input wire logic [6:0]              char_data,
   input wire logic                    char_avail,
   input wire logic                    display_int,
   input wire logic                    transmitting
);
   default clocking @(posedge ref_clk);
   endclocking
   default disable iff (sys_rst);
   sequence take_s;
      psel && penable && pready;
   endsequence
   sequence load_s;
      take_s ##0 (pwrite && paddr == `POCX_OFF_CTRL && pwdata[`POCX_CTRL_LOAD]);
   endsequence
   chk_refuse_busy: assert property (load_s ##0 transmitting
      |=> display_int && transmitting) else $error("load while sending not refused");
   chk_refuse_unavail: assert property (load_s ##0 (!transmitting && !char_demand)
      |=> display_int && !transmitting) else $error("load to idle printer not refused");
   chk_parity_odd: assert property (char_avail |-> char_data[6] == ~^char_data[5:0])
      else $error("parity line not odd");
   chk_avail_drop: assert property (char_avail && !char_demand |-> ##[1:2] !char_avail)
      else $error("available not dropped after demand fell");
   chk_data_hold: assert property ($past(char_avail) && char_avail |-> $stable(char_data))
      else $error("data changed while available");
   chk_avail_xmit: assert property (char_avail |-> transmitting)
      else $error("character offered while not transmitting");
   // a fall forced by reset is not a termination, so it raises no interrupt
   chk_end_int: assert property ($fell(transmitting) && !$past(sys_rst)
      |-> ##[0:2] display_int) else $error("no interrupt at end of sending");
   chk_stuck_low: assert property (transmitting && !char_avail && !char_demand
      |=> transmitting) else $error("transmitting lost while demand low");
   chk_apb_answer: assert property ($rose(penable) && psel |-> ##[1:64] pready)
      else $error("apb access not answered");
endmodule : pocx_channel_props

bind pocx_channel pocx_channel_props u_pocx_channel_props (
   .ref_clk(ref_clk), .sys_rst(sys_rst), .paddr(paddr), .psel(psel), .penable(penable),
   .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .char_demand(char_demand), .char_data(char_data), .char_avail(char_avail),
   .display_int(display_int), .transmitting(transmitting));

/* File: verif/pocx_printer_model.sv */
// Purpose: behavioural console printer on the character handshake
// Assumes: one character taken per rise of available while demand is high
// Notes:   LOW_CYC is the print pause; stuck_high pins demand true
`timescale 1ns/1ns
`include "pocx_map.svh"
module pocx_printer_model #(
   parameter int        LOW_CYC  = 500,
   parameter logic[5:0] END_CODE = `POCX_EOM_CODE,
   parameter logic[5:0] LC_CODE  = 6'h2E
) (
   // clock and reset
   input  wire logic       ref_clk,
   input  wire logic       sys_rst,
   // operator controls
   input  wire logic       online,
   input  wire logic       stuck_high,
   input  wire logic       err_clr,
   // handshake lines
   input  wire logic [6:0] char_data,
   input  wire logic       char_avail,
   output logic            char_demand,
   // observation
   output logic [15:0]     rx_count,
   output logic [5:0]      last_char,
   output logic [7:0]      feeds,
   output logic            err_lit
);
   int   busy;
   logic taken;
   wire  good = ^char_data;
   wire  take = online && busy == 0 && char_demand && char_avail && !taken;
   always_ff @(posedge ref_clk) begin
      if (err_clr) begin
         err_lit <= 1'b0;
      end else if (take && !good) begin
         err_lit <= 1'b1;
      end
   end
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         char_demand <= 1'b0;
         busy        <= 0;
         taken       <= 1'b0;
         rx_count    <= 16'h0;
         last_char   <= 6'h00;
         feeds       <= 8'h00;
      end else begin
         if (!char_avail) taken <= 1'b0;
         if (!online) begin
            char_demand <= 1'b0;
         end else if (busy > 0) begin
            busy <= busy - 1;
            char_demand <= (busy == 1);
         end else if (take) begin
            taken     <= 1'b1;
            rx_count  <= rx_count + 16'h1;
            // error symbol stand-in, reception goes on regardless
            last_char <= good ? char_data[5:0] : 6'h3F;
            if (char_data[5:0] == END_CODE || char_data[5:0] == LC_CODE) feeds <= feeds + 8'h1;
            if (!stuck_high) begin
               char_demand <= 1'b0;
               busy        <= LOW_CYC;
            end
         end else begin
            char_demand <= 1'b1;
         end
      end
   end
endmodule : pocx_printer_model

/* File: verif/pocx_channel_test.sv */
// Purpose: self-checking bench for the printer output channel
// Assumes: printer model with a 4 us print pause
// Notes:   region shortened to 8 characters to keep the run short
`timescale 1ns/1ns
`include "pocx_map.svh"
module pocx_channel_test;
   localparam int RC = 8;
   logic                    ref_clk = 1'b0, sys_rst = 1'b1;
   logic [`POCX_ADDR_W-1:0] paddr = 8'h00;
   logic                    psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [31:0]             pwdata = 32'h0, prdata, r;
   logic                    pready, pslverr, char_demand, char_avail, display_int, transmitting;
   logic [6:0]              char_data;
   logic                    online = 1'b1, stuck_high = 1'b0, err_clr = 1'b1, err_lit, e;
   logic [15:0]             rx_count;
   logic [5:0]              last_char;
   logic [7:0]              feeds;
   int                      mismatches = 0, comparisons = 0, ints = 0;
   ////////////////////////////////////////////////////////////////////////////
   always #4 ref_clk = ~ref_clk;
   always @(posedge ref_clk) if (display_int === 1'b1) ints++;
   pocx_channel #(.REGION_CHARS(RC)) u_pocx_channel (.ref_clk(ref_clk), .sys_rst(sys_rst),
      .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .char_demand(char_demand),
      .char_data(char_data), .char_avail(char_avail), .display_int(display_int),
      .transmitting(transmitting));
   pocx_printer_model u_pocx_printer_model (.ref_clk(ref_clk), .sys_rst(sys_rst),
      .online(online), .stuck_high(stuck_high), .err_clr(err_clr), .char_data(char_data),
      .char_avail(char_avail), .char_demand(char_demand), .rx_count(rx_count),
      .last_char(last_char), .feeds(feeds), .err_lit(err_lit));
   ////////////////////////////////////////////////////////////////////////////
   task complete_run;
      $display("mismatches %0d comparisons %0d", mismatches, comparisons);
      if (mismatches == 0 && comparisons > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : complete_run
   task check(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check
   task give_up;
      mismatches++;
      complete_run();
   endtask : give_up
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge ref_clk);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      do begin
         @(posedge ref_clk);
         n++;
      end while (pready !== 1'b1 && n < 100);
      if (n >= 100) give_up();
      r = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task wait_x(input logic v);
      int n;
      n = 0;
      while (transmitting !== v && n < 20000) begin
         @(posedge ref_clk);
         n++;
      end
      if (n >= 20000) give_up();
   endtask : wait_x
   task restart;
      sys_rst    <= 1'b1;
      err_clr    <= 1'b1;
      online     <= 1'b1;
      stuck_high <= 1'b0;
      repeat (2) @(posedge ref_clk);
      sys_rst <= 1'b0;
      err_clr <= 1'b0;
   endtask : restart
   // characters go out lowest six bits first
   task send(input int n, input logic [23:0] cs);
      apb(1'b1, `POCX_OFF_CTRL, 32'h1);
      for (int i = 0; i < n; i++) apb(1'b1, `POCX_OFF_DATA, {26'h0, cs[6*i +: 6]});
      apb(1'b1, `POCX_OFF_CTRL, 32'h2);
   endtask : send
   task s_send;
      int i0;
      restart();
      i0 = ints;
      send(3, {6'h05, 6'h2E, 6'h21});
      wait_x(1'b1);
      wait_x(1'b0);
      repeat (3) @(posedge ref_clk);
      check(32'(rx_count), 32'h3);
      check(32'(last_char), 32'h5);
      check(32'(feeds), 32'h1);
      check(32'(err_lit), 32'h0);
      check(32'(ints - i0), 32'h1);
      apb(1'b0, `POCX_OFF_COUNT, 32'h0);
      check(r, 32'h3);
      apb(1'b0, `POCX_OFF_STATUS, 32'h0);
      check(32'(r[`POCX_ST_XMIT]), 32'h0);
   endtask : s_send
   task s_end;
      restart();
      send(3, {6'h12, `POCX_EOM_CODE, 6'h11});
      wait_x(1'b1);
      wait_x(1'b0);
      check(32'(rx_count), 32'h2);
      check(32'(feeds), 32'h1);
   endtask : s_end
   task s_full;
      restart();
      apb(1'b1, `POCX_OFF_CTRL, 32'h1);
      for (int i = 1; i <= RC + 2; i++) apb(1'b1, `POCX_OFF_DATA, 32'(i));
      apb(1'b1, `POCX_OFF_CTRL, 32'h2);
      wait_x(1'b1);
      wait_x(1'b0);
      check(32'(rx_count), 32'(RC));
      check(32'(last_char), 32'(RC));
   endtask : s_full
   task s_stuck_high;
      int i0;
      restart();
      stuck_high <= 1'b1;
      send(2, {6'h22, 6'h21});
      wait_x(1'b1);
      repeat (700) @(posedge ref_clk);
      check(32'(rx_count), 32'h1);
      check(32'(transmitting), 32'h1);
      i0 = ints;
      apb(1'b1, `POCX_OFF_CTRL, 32'h1);
      repeat (2) @(posedge ref_clk);
      check(32'(ints - i0), 32'h1);
      apb(1'b0, `POCX_OFF_STATUS, 32'h0);
      check(r & 32'h5, 32'h5);
   endtask : s_stuck_high
   task s_unavail;
      int i0;
      restart();
      online <= 1'b0;
      repeat (3) @(posedge ref_clk);
      i0 = ints;
      apb(1'b1, `POCX_OFF_CTRL, 32'h1);
      repeat (2) @(posedge ref_clk);
      check(32'(ints - i0), 32'h1);
      apb(1'b0, `POCX_OFF_STATUS, 32'h0);
      check(r & 32'h7, 32'h6);
      apb(1'b1, `POCX_OFF_STATUS, 32'h6);
      apb(1'b0, `POCX_OFF_STATUS, 32'h0);
      check(r & 32'h7, 32'h0);
      apb(1'b0, 8'h10, 32'h0);
      check(32'(e), 32'h1);
   endtask : s_unavail
   task s_stuck_low;
      restart();
      send(2, {6'h22, 6'h21});
      wait_x(1'b1);
      online <= 1'b0;
      repeat (2000) @(posedge ref_clk);
      check(32'(transmitting), 32'h1);
   endtask : s_stuck_low
   initial begin
      s_send();
      s_end();
      s_full();
      s_stuck_high();
      s_unavail();
      s_stuck_low();
      complete_run();
   end
endmodule : pocx_channel_test
